// file: design/motion_block_regs.svh
// Register offsets, field positions, reset values and timing counts for the disable sequencer.
// How it works
// - No-telegram entry setting: interlock block, send nothing on either output.
// - Send-telegram entry setting: interlock, each output sends its configured entry telegram.
// - Each of the two outputs keeps its own entry telegram settings.
// - Switching or staircase outputs send selectable ON or OFF, default OFF.
// - Forced position outputs send forced ON, forced OFF or forced inactive.
// - Dimming value outputs send configured percentage 0 to 100, default 0.
// - Light scene outputs send configured scene 1 to 64, default 1.
// - Temperature outputs send 0 to 40 degrees in one-degree steps, default 21.
// - Brightness outputs send 0 to 2000 lux in 50 lux steps, default 750.
// - Operating mode outputs send auto, comfort, standby, night or frost protection.
// - No-telegram release: no motion, transmission delay inactive, nothing sent.
// - Extension type or detector application always uses no-telegram release.
// - End-of-detection release: send end reactions, no motion, delay marked active.
// - After end-of-detection release, ignore motion until lockout time has elapsed.
// - Start-of-detection release: simulate detection, start delay, send start telegrams.
// - Simulated detection with no real motion ends normally when delay expires.
// - Restore release: saved no motion acts as end, saved motion as start.
// - Disable entry clears running delays and freezes and saves the motion state.
// - Disable object polarity is configurable: 1 disables or 0 disables.
// - Alert application or extension type only interlocks, never sends entry telegrams.
`ifndef MOTION_BLOCK_REGS_SVH
`define MOTION_BLOCK_REGS_SVH

// Wishbone byte addresses.
`define MB_CTRL_ADDR 8'h00
`define MB_OUT0_ADDR 8'h04
`define MB_OUT1_ADDR 8'h08
`define MB_TIME_ADDR 8'h0c
`define MB_STAT_ADDR 8'h10
`define MB_DIS_ADDR 8'h14
`define MB_MOT_ADDR 8'h18

// Control register fields.
`define MB_CTRL_POL_BIT 0
`define MB_CTRL_ENTRY_BIT 1
`define MB_CTRL_REL_LSB 2
`define MB_CTRL_EXT_BIT 4
`define MB_CTRL_APP_LSB 5
`define MB_CTRL_RESET 32'h0000_0000

// Output setting fields: function, start, end and entry values.
`define MB_OUT_FUNC_LSB 0
`define MB_OUT_START_LSB 3
`define MB_OUT_END_LSB 12
`define MB_OUT_ENTRY_LSB 21
`define MB_OUT_VAL_W 9

// Entry value defaults per output function (scaled codes).
`define MB_DEF_SWITCH 9'h000
`define MB_DEF_DIM 9'h000
`define MB_DEF_SCENE 9'h001
`define MB_DEF_TEMP 9'h015
`define MB_DEF_BRIGHT 9'h00f
`define MB_ENTRY_RESET 9'h000

// Value limits.
`define MB_DIM_MAX 9'h064
`define MB_SCENE_MIN 9'h001
`define MB_SCENE_MAX 9'h040
`define MB_TEMP_MAX 9'h028
`define MB_BRIGHT_MAX 9'h028
`define MB_FORCE_MAX 9'h002
`define MB_MODE_MAX 9'h004

// Timing defaults in milliseconds and the clock rate.
`define MB_CLK_KHZ 125000
`define MB_DELAY_MS 1000
`define MB_LOCKOUT_MS 500

`endif

// file: design/motion_block_pkg.sv
// Types shared by the disable sequencer files.
package motion_block_pkg;

  typedef enum logic [2:0] {
    FN_SWITCH = 3'h0,
    FN_STAIR = 3'h1,
    FN_FORCE = 3'h2,
    FN_DIM = 3'h3,
    FN_SCENE = 3'h4,
    FN_TEMP = 3'h5,
    FN_BRIGHT = 3'h6,
    FN_MODE = 3'h7
  } out_func_t;

  typedef enum logic [1:0] {
    REL_NONE = 2'h0,
    REL_END = 2'h1,
    REL_START = 2'h2,
    REL_RESTORE = 2'h3
  } release_t;

  typedef enum logic [1:0] {
    APP_PRESENCE = 2'h0,
    APP_DETECTOR = 2'h1,
    APP_ALERT = 2'h2
  } app_t;

  typedef enum logic [1:0] {
    TG_ENTRY = 2'h0,
    TG_START = 2'h1,
    TG_END = 2'h2
  } tg_kind_t;

  // One telegram toward a bus actuator.
  typedef struct packed {
    logic valid;
    tg_kind_t kind;
    out_func_t func;
    logic [8:0] value;
  } telegram_t;

  // Per-output configuration.
  typedef struct packed {
    logic [1:0] spare;
    logic [8:0] entry_val;
    logic [8:0] end_val;
    logic [8:0] start_val;
    out_func_t func;
  } out_cfg_t;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_MOTION = 5'b00010,
    ST_LOCKOUT = 5'b00100,
    ST_DISABLED = 5'b01000,
    ST_SENDING = 5'b10000
  } mb_state_t;

endpackage

// file: design/output_cfg_reg.sv
// One output's configuration register with range clamping of the entry value.
`timescale 1ns/10ps
`include "motion_block_regs.svh"
module output_cfg_reg (
  input wire logic clk_i, // System clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic we_i, // Write strobe for this register.
  input wire logic [31:0] wdata_i, // Write data from the bus.
  output motion_block_pkg::out_cfg_t cfg_o // Stored, clamped configuration.
);

  motion_block_pkg::out_func_t func_w;
  logic [8:0] entry_raw;
  logic [8:0] entry_clamp;
  logic [8:0] start_raw;
  logic [8:0] end_raw;
  motion_block_pkg::out_cfg_t cfg_r;

  assign func_w = motion_block_pkg::out_func_t'(wdata_i[`MB_OUT_FUNC_LSB +: 3]);
  assign entry_raw = wdata_i[`MB_OUT_ENTRY_LSB +: `MB_OUT_VAL_W];
  assign start_raw = wdata_i[`MB_OUT_START_LSB +: `MB_OUT_VAL_W];
  assign end_raw = wdata_i[`MB_OUT_END_LSB +: `MB_OUT_VAL_W];

  // Clamp the entry value into the legal range of the chosen function.
  always_comb begin
    entry_clamp = entry_raw;
    case (func_w)
      motion_block_pkg::FN_SWITCH, motion_block_pkg::FN_STAIR: begin
        entry_clamp = {8'h00, entry_raw[0]};
      end
      motion_block_pkg::FN_FORCE: begin
        if (entry_raw > `MB_FORCE_MAX) entry_clamp = `MB_FORCE_MAX;
      end
      motion_block_pkg::FN_DIM: begin
        if (entry_raw > `MB_DIM_MAX) entry_clamp = `MB_DIM_MAX;
      end
      motion_block_pkg::FN_SCENE: begin
        if (entry_raw < `MB_SCENE_MIN) entry_clamp = `MB_SCENE_MIN;
        else if (entry_raw > `MB_SCENE_MAX) entry_clamp = `MB_SCENE_MAX;
      end
      motion_block_pkg::FN_TEMP: begin
        if (entry_raw > `MB_TEMP_MAX) entry_clamp = `MB_TEMP_MAX;
      end
      motion_block_pkg::FN_BRIGHT: begin
        if (entry_raw > `MB_BRIGHT_MAX) entry_clamp = `MB_BRIGHT_MAX;
      end
      motion_block_pkg::FN_MODE: begin
        if (entry_raw > `MB_MODE_MAX) entry_clamp = `MB_MODE_MAX;
      end
      default: entry_clamp = entry_raw;
    endcase
  end

  // Reset leaves a switching output with an OFF entry telegram.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r <= '0;
      cfg_r.entry_val <= `MB_ENTRY_RESET;
    end else if (we_i) begin
      cfg_r <= {2'b00, entry_clamp, end_raw, start_raw, func_w};
    end
  end

  assign cfg_o = cfg_r;

endmodule

// file: design/motion_block_disable_sequencer.sv
// Disable sequencer of one motion function block with a classic Wishbone slave.
//
// Added by the designer: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "motion_block_regs.svh"
module motion_block_disable_sequencer #(
  parameter int DELAY_CYC = (`MB_DELAY_MS * `MB_CLK_KHZ), // Transmission delay in cycles.
  parameter int LOCKOUT_CYC = (`MB_LOCKOUT_MS * `MB_CLK_KHZ) // Lockout time in cycles.
) (
  input wire logic clk_i, // System clock, 125 MHz.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic [7:0] wb_adr_i, // Wishbone byte address.
  input wire logic [31:0] wb_dat_i, // Wishbone write data.
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects.
  input wire logic wb_we_i, // Wishbone write enable.
  input wire logic wb_cyc_i, // Wishbone cycle.
  input wire logic wb_stb_i, // Wishbone strobe.
  output logic [31:0] wb_dat_o, // Wishbone read data.
  output logic wb_ack_o, // Wishbone acknowledge.
  input wire logic motion_i, // Motion pulse from sensor logic, same clock.
  output motion_block_pkg::telegram_t tg0_o, // Telegram on output 1.
  output motion_block_pkg::telegram_t tg1_o, // Telegram on output 2.
  output logic interlock_o, // Function block interlocked.
  output logic motion_state_o, // Current motion state.
  output logic delay_active_o // Transmission delay running.
);

  // Bus decode.
  logic req_w;
  logic wr_w;
  logic ack_r;
  logic sel_all_w;
  logic hit_ctrl_w;
  logic hit_out0_w;
  logic hit_out1_w;
  logic hit_dis_w;
  logic hit_mot_w;
  logic hit_stat_w;
  logic hit_time_w;
  logic [31:0] rdata_w;
  logic [31:0] rdata_r;

  assign req_w = wb_cyc_i && wb_stb_i && !ack_r;
  assign sel_all_w = (wb_sel_i == 4'hf);
  assign wr_w = req_w && wb_we_i && sel_all_w;
  assign hit_ctrl_w = (wb_adr_i == `MB_CTRL_ADDR);
  assign hit_out0_w = (wb_adr_i == `MB_OUT0_ADDR);
  assign hit_out1_w = (wb_adr_i == `MB_OUT1_ADDR);
  assign hit_time_w = (wb_adr_i == `MB_TIME_ADDR);
  assign hit_stat_w = (wb_adr_i == `MB_STAT_ADDR);
  assign hit_dis_w = (wb_adr_i == `MB_DIS_ADDR);
  assign hit_mot_w = (wb_adr_i == `MB_MOT_ADDR);

  // Control register and disable object.
  logic [31:0] ctrl_r;
  logic dis_obj_r;
  logic mot_wr_r;
  logic pol_w;
  logic entry_send_w;
  logic ext_w;
  motion_block_pkg::release_t rel_w;
  motion_block_pkg::app_t app_w;

  assign pol_w = ctrl_r[`MB_CTRL_POL_BIT];
  assign entry_send_w = ctrl_r[`MB_CTRL_ENTRY_BIT];
  assign rel_w = motion_block_pkg::release_t'(ctrl_r[`MB_CTRL_REL_LSB +: 2]);
  assign ext_w = ctrl_r[`MB_CTRL_EXT_BIT];
  assign app_w = motion_block_pkg::app_t'(ctrl_r[`MB_CTRL_APP_LSB +: 2]);

  // Writes of the control register and bus objects; a motion write of 1 also makes a pulse.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= `MB_CTRL_RESET;
      dis_obj_r <= 1'b0;
      mot_wr_r <= 1'b0;
    end else begin
      mot_wr_r <= wr_w && hit_mot_w && wb_dat_i[0];
      if (wr_w && hit_ctrl_w) ctrl_r <= {25'h0, wb_dat_i[6:0]};
      if (wr_w && hit_dis_w) dis_obj_r <= wb_dat_i[0];
    end
  end

  // Per-output configuration, each in its own register.
  motion_block_pkg::out_cfg_t cfg_w [2];
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_out
      output_cfg_reg u_cfg (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .we_i(wr_w && ((gi == 0) ? hit_out0_w : hit_out1_w)),
        .wdata_i(wb_dat_i),
        .cfg_o(cfg_w[gi])
      );
    end
  endgenerate

  // Disable level with polarity, and edge detection on real changes only.
  logic disabled_lvl_w;
  logic disabled_q_r;
  logic dis_rise_w;
  logic dis_fall_w;

  assign disabled_lvl_w = dis_obj_r ^ pol_w;
  assign dis_rise_w = disabled_lvl_w && !disabled_q_r;
  assign dis_fall_w = !disabled_lvl_w && disabled_q_r;

  // Effective release and entry behaviour after type and application overrides.
  motion_block_pkg::release_t rel_eff_w;
  logic entry_tx_w;

  assign rel_eff_w = (ext_w || app_w == motion_block_pkg::APP_DETECTOR) ?
                     motion_block_pkg::REL_NONE : rel_w;
  assign entry_tx_w = entry_send_w && !ext_w &&
                      (app_w != motion_block_pkg::APP_ALERT);

  // Sequencer state.
  motion_block_pkg::mb_state_t state_r;
  motion_block_pkg::mb_state_t state_nxt;
  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic saved_r;
  logic saved_nxt;
  logic motion_r;
  logic motion_nxt;
  logic delay_r;
  logic delay_nxt;
  logic send_r;
  logic send_nxt;
  motion_block_pkg::tg_kind_t kind_r;
  motion_block_pkg::tg_kind_t kind_nxt;
  logic motion_ev_w;
  logic cnt_zero_w;

  assign motion_ev_w = motion_i || mot_wr_r;
  assign cnt_zero_w = (cnt_r == 32'h0);

  // Next-state logic; a release or motion event chooses the telegram kind to send.
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_zero_w ? cnt_r : cnt_r - 32'h1;
    saved_nxt = saved_r;
    motion_nxt = motion_r;
    delay_nxt = delay_r;
    send_nxt = 1'b0;
    kind_nxt = kind_r;
    if (dis_rise_w) begin
      saved_nxt = motion_r;
      cnt_nxt = 32'h0;
      delay_nxt = 1'b0;
      state_nxt = motion_block_pkg::ST_DISABLED;
      send_nxt = entry_tx_w;
      kind_nxt = motion_block_pkg::TG_ENTRY;
    end else begin
      case (state_r)
        motion_block_pkg::ST_IDLE: begin
          if (motion_ev_w) begin
            state_nxt = motion_block_pkg::ST_MOTION;
            motion_nxt = 1'b1;
            delay_nxt = 1'b1;
            cnt_nxt = DELAY_CYC[31:0];
            send_nxt = 1'b1;
            kind_nxt = motion_block_pkg::TG_START;
          end
        end
        motion_block_pkg::ST_MOTION: begin
          if (motion_ev_w) begin
            cnt_nxt = DELAY_CYC[31:0];
          end else if (cnt_zero_w) begin
            state_nxt = motion_block_pkg::ST_LOCKOUT;
            motion_nxt = 1'b0;
            delay_nxt = 1'b1;
            cnt_nxt = LOCKOUT_CYC[31:0];
            send_nxt = 1'b1;
            kind_nxt = motion_block_pkg::TG_END;
          end
        end
        motion_block_pkg::ST_LOCKOUT: begin
          if (cnt_zero_w) begin
            state_nxt = motion_block_pkg::ST_IDLE;
            delay_nxt = 1'b0;
          end
        end
        motion_block_pkg::ST_DISABLED: begin
          // Motion events are dropped here while interlocked.
          if (dis_fall_w) begin
            case (rel_eff_w)
              motion_block_pkg::REL_END: kind_nxt = motion_block_pkg::TG_END;
              motion_block_pkg::REL_START: kind_nxt = motion_block_pkg::TG_START;
              motion_block_pkg::REL_RESTORE: begin
                kind_nxt = saved_r ? motion_block_pkg::TG_START :
                           motion_block_pkg::TG_END;
              end
              default: kind_nxt = motion_block_pkg::TG_END;
            endcase
            if (rel_eff_w == motion_block_pkg::REL_NONE) begin
              state_nxt = motion_block_pkg::ST_IDLE;
              motion_nxt = 1'b0;
              delay_nxt = 1'b0;
            end else begin
              state_nxt = motion_block_pkg::ST_SENDING;
              send_nxt = 1'b1;
            end
          end
        end
        motion_block_pkg::ST_SENDING: begin
          delay_nxt = 1'b1;
          if (kind_r == motion_block_pkg::TG_START) begin
            state_nxt = motion_block_pkg::ST_MOTION;
            motion_nxt = 1'b1;
            cnt_nxt = DELAY_CYC[31:0];
          end else begin
            state_nxt = motion_block_pkg::ST_LOCKOUT;
            motion_nxt = 1'b0;
            cnt_nxt = LOCKOUT_CYC[31:0];
          end
        end
        default: state_nxt = motion_block_pkg::ST_IDLE;
      endcase
    end
  end

  // State registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= motion_block_pkg::ST_IDLE;
      cnt_r <= 32'h0;
      saved_r <= 1'b0;
      motion_r <= 1'b0;
      delay_r <= 1'b0;
      send_r <= 1'b0;
      kind_r <= motion_block_pkg::TG_ENTRY;
      disabled_q_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      saved_r <= saved_nxt;
      motion_r <= motion_nxt;
      delay_r <= delay_nxt;
      send_r <= send_nxt;
      kind_r <= kind_nxt;
      disabled_q_r <= disabled_lvl_w;
    end
  end

  // Telegram value selection per output.
  motion_block_pkg::telegram_t tg_nxt [2];
  motion_block_pkg::telegram_t tg_r [2];
  generate
    for (gi = 0; gi < 2; gi++) begin : g_tg
      assign tg_nxt[gi].valid = send_r;
      assign tg_nxt[gi].kind = kind_r;
      assign tg_nxt[gi].func = cfg_w[gi].func;
      assign tg_nxt[gi].value = (kind_r == motion_block_pkg::TG_ENTRY) ? cfg_w[gi].entry_val :
                                (kind_r == motion_block_pkg::TG_START) ? cfg_w[gi].start_val :
                                cfg_w[gi].end_val;
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          tg_r[gi] <= '0;
        end else begin
          tg_r[gi] <= tg_nxt[gi];
        end
      end
    end
  endgenerate

  assign tg0_o = tg_r[0];
  assign tg1_o = tg_r[1];
  assign interlock_o = (state_r == motion_block_pkg::ST_DISABLED);
  assign motion_state_o = motion_r;
  assign delay_active_o = delay_r;

  // Read multiplexer; unmapped addresses read zero but still acknowledge.
  assign rdata_w = hit_ctrl_w ? ctrl_r :
                   hit_out0_w ? cfg_w[0] :
                   hit_out1_w ? cfg_w[1] :
                   hit_dis_w ? {31'h0, dis_obj_r} :
                   hit_stat_w ? {24'h0, state_r, delay_r, motion_r, interlock_o} :
                   hit_time_w ? cnt_r : 32'h0;

  // Acknowledge one cycle after the request; ack falls in the following cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      ack_r <= req_w;
      rdata_r <= rdata_w;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

endmodule

// file: sim/bus_actuator_model.sv
// Behavioural bus actuator that logs the telegrams one output sends.
`timescale 1ns/10ps
module bus_actuator_model (
  input wire logic clk_i, // System clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire motion_block_pkg::telegram_t tg_i // Telegram from one output.
);
  int count;
  motion_block_pkg::telegram_t last;

  // An actuator only listens, so a tally is kept to expose repeats or missing telegrams.
  always @(posedge clk_i) begin
    if (rst_i) begin
      count <= 0;
      last <= '0;
    end else if (tg_i.valid === 1'b1) begin
      count <= count + 1;
      last <= tg_i;
    end
  end
endmodule

// file: sim/motion_block_disable_sequencer_properties.sv
// Concurrent checks on the ports of the motion block disable sequencer.
`timescale 1ns/10ps
module motion_block_properties (
  input wire logic clk_i, // System clock.
  input wire logic rst_i, // Synchronous reset.
  input wire logic wb_cyc_i, // Bus cycle.
  input wire logic wb_stb_i, // Bus strobe.
  input wire logic wb_ack_o, // Bus acknowledge.
  input wire motion_block_pkg::telegram_t tg0_o, // Output 1 telegram.
  input wire motion_block_pkg::telegram_t tg1_o, // Output 2 telegram.
  input wire logic interlock_o, // Interlock state.
  input wire logic motion_state_o, // Motion state.
  input wire logic delay_active_o // Delay running.
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Telegram kind decodes keep the properties short.
  wire logic ent0 = tg0_o.valid && tg0_o.kind == motion_block_pkg::TG_ENTRY;
  wire logic ent1 = tg1_o.valid && tg1_o.kind == motion_block_pkg::TG_ENTRY;
  wire logic st0 = tg0_o.valid && tg0_o.kind == motion_block_pkg::TG_START;
  wire logic end0 = tg0_o.valid && tg0_o.kind == motion_block_pkg::TG_END;

  ack_latency_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack did not follow a request by one cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack stood longer than one cycle");
  entry_locked_a: assert property (ent0 |-> interlock_o)
    else $error("entry telegram sent outside the interlock");
  entry_both_a: assert property (ent0 |-> ent1)
    else $error("entry telegram missing on output 2");
  quiet_locked_a: assert property (interlock_o && tg0_o.valid |-> ent0)
    else $error("detection telegram sent while interlocked");
  state_frozen_a: assert property (interlock_o && $past(interlock_o) |-> $stable(motion_state_o))
    else $error("motion state changed while interlocked");
  delay_cleared_a: assert property (interlock_o && $past(interlock_o, 2) |-> !delay_active_o)
    else $error("delay still running while interlocked");
  start_delay_a: assert property (st0 |-> ##[0:2] delay_active_o)
    else $error("start telegram without running delay");
  end_nomotion_a: assert property (end0 |-> ##[0:2] !motion_state_o)
    else $error("end telegram left motion state set");
  tg_pulse_a: assert property (tg0_o.valid |=> !tg0_o.valid)
    else $error("telegram valid stood longer than one cycle");

  cover property (ent0);
  cover property (st0 && !interlock_o);
  cover property ($fell(interlock_o));
endmodule

bind motion_block_disable_sequencer motion_block_properties u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .tg0_o(tg0_o), .tg1_o(tg1_o), .interlock_o(interlock_o),
  .motion_state_o(motion_state_o), .delay_active_o(delay_active_o)
);

// file: sim/tb_motion_block_disable_sequencer.sv
// Self-checking bench for the motion block disable sequencer.
`timescale 1ns/10ps
`include "motion_block_regs.svh"
module tb_motion_block_disable_sequencer;
  logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, motion_i, wb_ack_o;
  logic interlock_o, motion_state_o, delay_active_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd, seed;
  logic [8:0] e0, e1, s0, s1, n0, n1;
  motion_block_pkg::telegram_t tg0_o, tg1_o;
  int mismatches, n_tests, cyc_cnt;
  int modv[8] = '{2, 2, 3, 101, 64, 41, 41, 5};
  int tbl[3][3] = '{'{32'h1a, 0, 0}, '{32'h2a, 1, 0}, '{32'h42, 0, 0}};

  // Short delay and lockout keep the run brief; expectations use the same values.
  motion_block_disable_sequencer #(.DELAY_CYC(30), .LOCKOUT_CYC(16)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .motion_i(motion_i), .tg0_o(tg0_o),
    .tg1_o(tg1_o), .interlock_o(interlock_o), .motion_state_o(motion_state_o),
    .delay_active_o(delay_active_o));
  bus_actuator_model act0 (.clk_i(clk_i), .rst_i(rst_i), .tg_i(tg0_o));
  bus_actuator_model act1 (.clk_i(clk_i), .rst_i(rst_i), .tg_i(tg1_o));

  // Free-running 125 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  // A hang is cut short at 20000 cycles, well above the thousand or so cycles the run needs.
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      mismatches++;
      conclude();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // In-range telegram code for a function; scenes start at one.
  function automatic logic [8:0] pick(input int f, input logic [31:0] r);
    return 9'(r % modv[f] + (f == 4 ? 1 : 0));
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // The request is held until ack is sampled high, then dropped for a cycle.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic cfg(input logic [7:0] adr, input int f, input logic [8:0] en, input logic [8:0] st,
                     input logic [8:0] nd);
    logic [31:0] w;
    w = (32'(en) << `MB_OUT_ENTRY_LSB) | (32'(nd) << `MB_OUT_END_LSB)
        | (32'(st) << `MB_OUT_START_LSB) | 32'(f);
    wb(1'b1, adr, w);
    wb(1'b0, adr, 32'h0);
    check("out cfg", rd, w);
  endtask

  // Writes the disable object or a motion event and counts what reaches the actuators.
  task automatic act(input logic [7:0] adr, input logic [31:0] v, input int n,
                     input logic [1:0] k, input logic [8:0] v0, input logic [8:0] v1);
    int c0;
    int c1;
    c0 = act0.count;
    c1 = act1.count;
    if (adr == 8'hff) begin
      @(posedge clk_i);
      motion_i <= 1'b1;
      @(posedge clk_i);
      motion_i <= 1'b0;
    end else begin
      wb(1'b1, adr, v);
    end
    repeat (6) @(posedge clk_i);
    check("out1 count", act0.count - c0, n);
    check("out2 count", act1.count - c1, n);
    if (n > 0) begin
      check("out1 tg", {act0.last.kind, act0.last.value}, {k, v0});
      check("out2 tg", {act1.last.kind, act1.last.value}, {k, v1});
    end
  endtask

  task automatic conclude();
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence: reset, register map, every output function, every release mode.
  initial begin
    {wb_we_i, wb_cyc_i, wb_stb_i, motion_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hf;
    {mismatches, n_tests, cyc_cnt} = '0;
    seed = 32'h50fe;
    rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `MB_CTRL_ADDR, 32'h0);
    check("ctrl reset", rd, `MB_CTRL_RESET);
    wb(1'b0, 8'h1c, 32'h0);
    check("unmapped", rd, 32'h0);
    // A partial-select write is acknowledged but must leave the register alone.
    wb_sel_i <= 4'h3;
    wb(1'b1, `MB_CTRL_ADDR, 32'h7f);
    wb_sel_i <= 4'hf;
    wb(1'b0, `MB_CTRL_ADDR, 32'h0);
    check("sel refused", rd, `MB_CTRL_RESET);
    wb(1'b1, `MB_CTRL_ADDR, 32'h2);
    for (int f = 0; f < 8; f++) begin
      seed = lfsr(seed);
      e0 = pick(f, seed);
      seed = lfsr(seed);
      e1 = pick(7 - f, seed);
      cfg(`MB_OUT0_ADDR, f, e0, 9'h0, 9'h0);
      cfg(`MB_OUT1_ADDR, 7 - f, e1, 9'h0, 9'h0);
      act(`MB_DIS_ADDR, 1, 1, 2'h0, e0, e1);
      act(8'hff, 0, 0, 2'h0, 0, 0);
      act(`MB_MOT_ADDR, 1, 0, 2'h0, 0, 0);
      act(`MB_DIS_ADDR, 1, 0, 2'h0, 0, 0);
      act(`MB_DIS_ADDR, 0, 0, 2'h0, 0, 0);
      check("no motion", {interlock_o, motion_state_o, delay_active_o}, 3'b000);
    end
    seed = lfsr(seed);
    {e0, e1, s0, s1} = {pick(3, seed), pick(3, seed >> 7), pick(3, seed >> 13), pick(3, seed >> 19)};
    seed = lfsr(seed);
    {n0, n1} = {pick(3, seed), pick(3, seed >> 9)};
    cfg(`MB_OUT0_ADDR, 3, e0, s0, n0);
    cfg(`MB_OUT1_ADDR, 3, e1, s1, n1);
    wb(1'b1, `MB_CTRL_ADDR, 32'h6);
    act(`MB_DIS_ADDR, 1, 1, 2'h0, e0, e1);
    act(`MB_DIS_ADDR, 0, 1, 2'h2, n0, n1);
    check("end state", {motion_state_o, delay_active_o}, 2'b01);
    act(8'hff, 0, 0, 2'h0, 0, 0);
    repeat (30) @(posedge clk_i);
    act(8'hff, 0, 1, 2'h1, s0, s1);
    repeat (40) @(posedge clk_i);
    wb(1'b1, `MB_CTRL_ADDR, 32'ha);
    act(`MB_DIS_ADDR, 1, 1, 2'h0, e0, e1);
    act(`MB_DIS_ADDR, 0, 1, 2'h1, s0, s1);
    check("sim motion", {motion_state_o, delay_active_o}, 2'b11);
    act(8'hff, 8'h0, 0, 2'h0, 0, 0);
    act(`MB_MOT_ADDR, 0, 0, 2'h0, 0, 0);
    repeat (30) @(posedge clk_i);
    check("sim end", {act0.last.kind, act0.last.value, motion_state_o}, {2'h2, n0, 1'b0});
    repeat (30) @(posedge clk_i);
    wb(1'b1, `MB_CTRL_ADDR, 32'hc);
    act(`MB_DIS_ADDR, 1, 0, 2'h0, 0, 0);
    act(`MB_DIS_ADDR, 0, 1, 2'h2, n0, n1);
    repeat (40) @(posedge clk_i);
    act(8'hff, 0, 1, 2'h1, s0, s1);
    act(`MB_DIS_ADDR, 1, 0, 2'h0, 0, 0);
    act(`MB_DIS_ADDR, 0, 1, 2'h1, s0, s1);
    repeat (80) @(posedge clk_i);
    wb(1'b1, `MB_CTRL_ADDR, 32'h1);
    act(`MB_DIS_ADDR, 0, 0, 2'h0, 0, 0);
    check("pol low", interlock_o, 1'b1);
    act(`MB_DIS_ADDR, 1, 0, 2'h0, 0, 0);
    check("pol high", interlock_o, 1'b0);
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, `MB_CTRL_ADDR, tbl[i][0]);
      act(`MB_DIS_ADDR, 1, tbl[i][1], 2'h0, e0, e1);
      act(`MB_DIS_ADDR, 0, tbl[i][2], 2'h0, 0, 0);
      repeat (40) @(posedge clk_i);
    end
    conclude();
  end
endmodule
